// ### rtl/ssd_pkg.sv
package ssd_pkg;

    // clock and probe timing
    localparam int unsigned CLK_PERIOD_NS = 100;
    localparam int unsigned PROBE_SETTLE_NS = 1000;
    // least settle time, rounded up to whole cycles
    localparam int unsigned PROBE_CYC = (PROBE_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned CNT_W = 4;
    localparam logic [CNT_W-1:0] PROBE_LAST = CNT_W'(PROBE_CYC - 1);
    localparam logic [CNT_W-1:0] CNT_RST = 4'h0;

    // strap pin indices
    localparam int unsigned NUM_STRAP = 3;
    localparam int unsigned PIN_SWING = 0;
    localparam int unsigned PIN_EDGE = 1;
    localparam int unsigned PIN_MODE = 2;

    // register map (byte addresses)
    localparam int unsigned ADDR_W = 12;
    localparam logic [ADDR_W-1:0] REG_STATUS = 12'h000;
    localparam logic [ADDR_W-1:0] REG_CTRL = 12'h004;
    localparam logic [ADDR_W-1:0] REG_CONFIG = 12'h008;

    // field positions
    localparam int unsigned CTRL_REPROBE_BIT = 0;
    localparam int unsigned ST_PIN_LSB = 0;
    localparam int unsigned ST_VALID_BIT = 8;
    localparam int unsigned ST_EXT_BIT = 9;
    localparam int unsigned ST_FAULT_BIT = 10;
    localparam int unsigned ST_PROBING_BIT = 11;
    localparam int unsigned CF_RANGE_BIT = 0;
    localparam int unsigned CF_SWING_BIT = 1;
    localparam int unsigned CF_EDGE_BIT = 2;
    localparam int unsigned CF_DDR_BIT = 3;

    typedef enum logic [1:0] {SSD_PIN_LOW, SSD_PIN_HIGH, SSD_PIN_FLOAT} ssd_pin_e;
    typedef enum logic [1:0] {SSD_DRV_HI, SSD_DRV_LO, SSD_RESOLVE, SSD_HOLD} ssd_probe_e;

    typedef struct packed {
        logic range_870;
        logic swing_700;
        logic edge_pos;
        logic ddr;
        logic ext_ctrl;
        logic valid;
        logic swing_fault;
    } ssd_cfg_s;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [ADDR_W-1:0] paddr;
        logic [31:0] pwdata;
    } ssd_apb_req_s;

    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } ssd_apb_rsp_s;

    // values after reset
    localparam ssd_cfg_s CFG_RST = '0;
    localparam ssd_pin_e PIN_RST = SSD_PIN_LOW;
    localparam ssd_probe_e PROBE_RST = SSD_DRV_HI;
    localparam logic [31:0] RDATA_RST = 32'h0000_0000;

endpackage : ssd_pkg

// ### rtl/ssd_strap_decoder.sv
// Behaviour
// - firm mode pin: serial port stays inactive, settings come from strap pins
// - extended control mode only when mode pin floats; board must leave it open
// - strapped mode: mode pin low gives 650 mV range, high gives 870 mV
// - strapped mode: swing pin low gives 0.50 V, high 0.70 V; float is a fault
// - strapped mode: edge pin low selects negative edge, high positive edge
// - strapped mode: edge pin floating selects double data rate; edge choice then ignored
// - extended mode: swing pin is serial clock, edge pin data, select comes from serial_port_select_n_i
`timescale 1ns/1ps
module ssd_strap_decoder
    import ssd_pkg::*;
(
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic rstn_i,
    // apb slave
    input wire ssd_apb_req_s apb_i,
    output ssd_apb_rsp_s apb_o,
    // strap pins: swing/serial clock, edge/serial data, mode
    input wire logic [NUM_STRAP-1:0] strap_in_i,
    output logic [NUM_STRAP-1:0] strap_out_o,
    output logic [NUM_STRAP-1:0] strap_oe_o,
    input wire logic serial_port_select_n_i,
    // decoded configuration
    output ssd_cfg_s cfg_o,
    // serial control port towards the register logic
    output logic serial_clk_o,
    output logic serial_port_data_o,
    output logic serial_port_select_o
);

    localparam int PROBE_DLY = PROBE_CYC;

    ssd_probe_e state;
    ssd_probe_e next_state;
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] next_cnt;
    logic [NUM_STRAP-1:0] hi_seen;
    logic [NUM_STRAP-1:0] next_hi_seen;
    logic [NUM_STRAP-1:0] lo_seen;
    logic [NUM_STRAP-1:0] next_lo_seen;
    ssd_pin_e pin_dec [NUM_STRAP];
    ssd_pin_e pin_state [NUM_STRAP];
    ssd_pin_e next_pin_state [NUM_STRAP];
    ssd_cfg_s cfg_q;
    ssd_cfg_s next_cfg;
    logic sclk;
    logic next_sclk;
    logic serial_port_data;
    logic next_serial_port_data;
    logic ssel;
    logic next_ssel;
    logic [31:0] rdata;
    logic [31:0] next_rdata;
    logic slverr;
    logic next_slverr;
    logic apb_setup;
    logic apb_access;
    logic reprobe_wr;
    logic serial_live;
    logic probing;

    assign apb_setup = apb_i.psel && !apb_i.penable;
    assign apb_access = apb_i.psel && apb_i.penable;
    assign reprobe_wr = apb_access && apb_i.pwrite && (apb_i.paddr == REG_CTRL)
        && apb_i.pwdata[CTRL_REPROBE_BIT];
    assign probing = (state == SSD_DRV_HI) || (state == SSD_DRV_LO);

    // weak drive high then low; a pin that follows both ways is floating
    assign strap_oe_o = probing ? 3'h7 : 3'h0;
    assign strap_out_o = (state == SSD_DRV_HI) ? 3'h7 : 3'h0;

    // per-pin capture and decode
    for (genvar gi = 0; gi < NUM_STRAP; gi++)
    begin : g_pin
        assign next_hi_seen[gi] = ((state == SSD_DRV_HI) && (cnt == PROBE_LAST))
            ? strap_in_i[gi] : hi_seen[gi];
        assign next_lo_seen[gi] = ((state == SSD_DRV_LO) && (cnt == PROBE_LAST))
            ? strap_in_i[gi] : lo_seen[gi];
        // a firm high wins over our weak low, a firm low over our weak high
        assign pin_dec[gi] = (hi_seen[gi] && !lo_seen[gi]) ? SSD_PIN_FLOAT
            : (lo_seen[gi] ? SSD_PIN_HIGH : SSD_PIN_LOW);
        assign next_pin_state[gi] = (state == SSD_RESOLVE) ? pin_dec[gi] : pin_state[gi];
    end

    // probe sequencer; reprobe only honoured once settled
    always_comb
    begin
        next_state = state;
        next_cnt = cnt;
        case (state)
            SSD_DRV_HI, SSD_DRV_LO:
            begin
                if (cnt == PROBE_LAST)
                begin
                    next_cnt = CNT_RST;
                    next_state = (state == SSD_DRV_HI) ? SSD_DRV_LO : SSD_RESOLVE;
                end
                else
                begin
                    next_cnt = cnt + 4'h1;
                end
            end
            SSD_RESOLVE:
            begin
                next_state = SSD_HOLD;
            end
            SSD_HOLD:
            begin
                // static once resolved, pins are left alone
                if (reprobe_wr)
                begin
                    next_state = SSD_DRV_HI;
                end
            end
            default:
            begin
                next_state = PROBE_RST;
                next_cnt = CNT_RST;
            end
        endcase
    end

    always_ff @(posedge sys_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            state <= PROBE_RST;
            cnt <= CNT_RST;
            hi_seen <= 3'h0;
            lo_seen <= 3'h0;
        end
        else
        begin
            state <= next_state;
            cnt <= next_cnt;
            hi_seen <= next_hi_seen;
            lo_seen <= next_lo_seen;
        end
    end

    // configuration decode
    always_comb
    begin
        next_cfg = cfg_q;
        if (state == SSD_DRV_HI)
        begin
            next_cfg.valid = 1'b0;
        end
        else if (state == SSD_RESOLVE)
        begin
            next_cfg = CFG_RST;
            next_cfg.valid = 1'b1;
            if (pin_dec[PIN_MODE] == SSD_PIN_FLOAT)
            begin
                // settings belong to the serial registers now
                next_cfg.ext_ctrl = 1'b1;
            end
            else
            begin
                next_cfg.range_870 = (pin_dec[PIN_MODE] == SSD_PIN_HIGH);
                next_cfg.swing_700 = (pin_dec[PIN_SWING] == SSD_PIN_HIGH);
                next_cfg.swing_fault = (pin_dec[PIN_SWING] == SSD_PIN_FLOAT);
                next_cfg.ddr = (pin_dec[PIN_EDGE] == SSD_PIN_FLOAT);
                next_cfg.edge_pos = (pin_dec[PIN_EDGE] == SSD_PIN_HIGH);
            end
        end
    end

    always_ff @(posedge sys_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            cfg_q <= CFG_RST;
            for (int i = 0; i < NUM_STRAP; i++)
            begin
                pin_state[i] <= PIN_RST;
            end
        end
        else
        begin
            cfg_q <= next_cfg;
            pin_state <= next_pin_state;
        end
    end

    assign cfg_o = cfg_q;

    // serial port pins pass through only in settled extended mode
    assign serial_live = (state == SSD_HOLD) && cfg_q.ext_ctrl && cfg_q.valid;

    always_comb
    begin
        next_sclk = serial_live && strap_in_i[PIN_SWING];
        next_serial_port_data = serial_live && strap_in_i[PIN_EDGE];
        next_ssel = serial_live && !serial_port_select_n_i;
    end

    always_ff @(posedge sys_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            sclk <= 1'b0;
            serial_port_data <= 1'b0;
            ssel <= 1'b0;
        end
        else
        begin
            sclk <= next_sclk;
            serial_port_data <= next_serial_port_data;
            ssel <= next_ssel;
        end
    end

    assign serial_clk_o = sclk;
    assign serial_port_data_o = serial_port_data;
    assign serial_port_select_o = ssel;

    // apb: read data captured in setup so the access phase answers at once
    always_comb
    begin
        next_rdata = rdata;
        next_slverr = slverr;
        if (apb_setup)
        begin
            next_rdata = RDATA_RST;
            next_slverr = 1'b0;
            case (apb_i.paddr)
                REG_STATUS:
                begin
                    for (int i = 0; i < NUM_STRAP; i++)
                    begin
                        next_rdata[ST_PIN_LSB + 2 * i +: 2] = pin_state[i];
                    end
                    next_rdata[ST_VALID_BIT] = cfg_q.valid;
                    next_rdata[ST_EXT_BIT] = cfg_q.ext_ctrl;
                    next_rdata[ST_FAULT_BIT] = cfg_q.swing_fault;
                    next_rdata[ST_PROBING_BIT] = probing;
                end
                REG_CONFIG:
                begin
                    next_rdata[CF_RANGE_BIT] = cfg_q.range_870;
                    next_rdata[CF_SWING_BIT] = cfg_q.swing_700;
                    next_rdata[CF_EDGE_BIT] = cfg_q.edge_pos;
                    next_rdata[CF_DDR_BIT] = cfg_q.ddr;
                end
                REG_CTRL:
                begin
                    next_rdata = RDATA_RST;
                end
                default:
                begin
                    next_slverr = 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            rdata <= RDATA_RST;
            slverr <= 1'b0;
        end
        else
        begin
            rdata <= next_rdata;
            slverr <= next_slverr;
        end
    end

    assign apb_o.pready = apb_access;
    assign apb_o.pslverr = apb_access && slverr;
    assign apb_o.prdata = rdata;

    sequence s_resolve;
        state == SSD_RESOLVE;
    endsequence

    sequence s_enter_hi;
        (state == SSD_DRV_HI) && ($past(state) != SSD_DRV_HI);
    endsequence

    a_strap_serial_quiet: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        (state == SSD_HOLD) && !cfg_q.ext_ctrl |=> !serial_clk_o && !serial_port_data_o
        && !serial_port_select_o)
        else $error("serial port active in strapped mode");

    a_float_mode_ext: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        s_resolve |=> cfg_q.ext_ctrl == $past(hi_seen[PIN_MODE] && !lo_seen[PIN_MODE]))
        else $error("extended mode does not follow floating mode pin");

    a_range_select: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        s_resolve ##1 !cfg_q.ext_ctrl |-> cfg_q.range_870 == $past(lo_seen[PIN_MODE]))
        else $error("input range does not follow mode pin");

    a_swing_select: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        s_resolve ##1 !cfg_q.ext_ctrl |-> cfg_q.swing_fault
        ? !cfg_q.swing_700 : (cfg_q.swing_700 == $past(lo_seen[PIN_SWING])))
        else $error("output swing does not follow swing pin");

    a_edge_select: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        s_resolve ##1 (!cfg_q.ext_ctrl && !cfg_q.ddr)
        |-> cfg_q.edge_pos == $past(lo_seen[PIN_EDGE]))
        else $error("output edge does not follow edge pin");

    a_ddr_float: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        s_resolve ##1 cfg_q.ddr |-> !cfg_q.edge_pos && !cfg_q.ext_ctrl
        && $past(hi_seen[PIN_EDGE] && !lo_seen[PIN_EDGE]))
        else $error("double data rate without floating edge pin");

    a_serial_map: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        serial_live |=> serial_clk_o == $past(strap_in_i[PIN_SWING])
        && serial_port_data_o == $past(strap_in_i[PIN_EDGE])
        && serial_port_select_o == !$past(serial_port_select_n_i))
        else $error("serial pins not mapped in extended mode");

    a_probe_timing: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        s_enter_hi |-> ##PROBE_DLY (state == SSD_DRV_LO) ##PROBE_DLY s_resolve)
        else $error("probe phases have wrong length");

    a_probe_release: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        (state == SSD_HOLD) |-> (strap_oe_o == 3'h0) ##1 $stable(cfg_q))
        else $error("strap pins disturbed after resolution");

endmodule : ssd_strap_decoder

// ### sim/ssd_strap_board.sv
`timescale 1ns/1ps
module ssd_strap_board
    import ssd_pkg::*;
(
    // clock
    input wire logic sys_clk_i,
    // strap fitting chosen by the bench, per pin
    input wire ssd_pin_e [NUM_STRAP-1:0] pin_st_i,
    // weak probe drive from the decoder
    input wire logic [NUM_STRAP-1:0] drv_out_i,
    input wire logic [NUM_STRAP-1:0] drv_oe_i,
    // resolved pin levels
    output logic [NUM_STRAP-1:0] strap_o
);
    logic wander = 1'b0;
    // an undriven open pin has no pull: show a level that keeps moving
    always @(posedge sys_clk_i)
        wander <= ~wander;
    always_comb
    begin
        for (int i = 0; i < NUM_STRAP; i++)
        begin
            // firm strap wins over the weak probe; an open pin follows it
            case (pin_st_i[i])
                SSD_PIN_LOW: strap_o[i] = 1'b0;
                SSD_PIN_HIGH: strap_o[i] = 1'b1;
                default: strap_o[i] = drv_oe_i[i] ? drv_out_i[i] : wander ^ i[0];
            endcase
        end
    end
endmodule : ssd_strap_board

// ### sim/test_ssd_strap_decoder.sv
`timescale 1ns/1ps
module test_ssd_strap_decoder;
    import ssd_pkg::*;
    logic sys_clk_i = 1'b0;
    logic rstn_i = 1'b0;
    logic sel_n = 1'b1;
    ssd_apb_req_s apb_req = '0;
    ssd_apb_rsp_s apb_rsp;
    ssd_pin_e [NUM_STRAP-1:0] pin_st = {SSD_PIN_LOW, SSD_PIN_LOW, SSD_PIN_LOW};
    logic [NUM_STRAP-1:0] strap_in, strap_out, strap_oe;
    ssd_cfg_s cfg, exp;
    logic ser_clk, ser_dat, ser_sel;
    logic [31:0] rd;
    logic err;
    int error_cnt = 0;
    int compares = 0;
    int cyc = 0;
    int seed = 32'h8E70;

    always #50 sys_clk_i = ~sys_clk_i;

    ssd_strap_decoder uut (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .apb_i(apb_req),
        .apb_o(apb_rsp), .strap_in_i(strap_in), .strap_out_o(strap_out),
        .strap_oe_o(strap_oe), .serial_port_select_n_i(sel_n), .cfg_o(cfg),
        .serial_clk_o(ser_clk), .serial_port_data_o(ser_dat), .serial_port_select_o(ser_sel));
    ssd_strap_board board (.sys_clk_i(sys_clk_i), .pin_st_i(pin_st), .drv_out_i(strap_out),
        .drv_oe_i(strap_oe), .strap_o(strap_in));

    task automatic final_report();
        $display("checks %0d, mismatches %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : final_report

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] want);
        compares++;
        if (seen !== want)
        begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", name, want, seen);
        end
    endtask : check

    // hang guard: a full sweep needs well under 3000 cycles
    always @(posedge sys_clk_i)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            error_cnt++;
            final_report();
        end
    end

    task automatic apb(input logic wr, input logic [ADDR_W-1:0] addr, input logic [31:0] wd,
        output logic [31:0] rdata, output logic slverr);
        @(posedge sys_clk_i);
        apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: addr, pwdata: wd};
        @(posedge sys_clk_i);
        apb_req.penable <= 1'b1;
        do
            @(posedge sys_clk_i);
        while (apb_rsp.pready !== 1'b1);
        rdata = apb_rsp.prdata;
        slverr = apb_rsp.pslverr;
        apb_req <= '0;
    endtask : apb

    task automatic wait_valid();
        int n;
        n = 0;
        while (cfg.valid !== 1'b1 && n < 40)
        begin
            @(posedge sys_clk_i);
            n++;
        end
        #1;
    endtask : wait_valid

    // reference decode of the three strap states
    function automatic ssd_cfg_s model(input int m, input int s, input int e);
        ssd_cfg_s c;
        c = '0;
        c.valid = 1'b1;
        c.ext_ctrl = (m == 2);
        if (m != 2)
        begin
            c.range_870 = (m == 1);
            c.swing_700 = (s == 1);
            c.swing_fault = (s == 2);
            c.ddr = (e == 2);
            c.edge_pos = (e == 1);
        end
        return c;
    endfunction : model

    initial
    begin
        logic [2:0] rnd;
        repeat (16) @(posedge sys_clk_i);
        check("reset cfg", 32'(cfg), 32'h0);
        check("reset oe", 32'(strap_oe), 32'h7);
        rstn_i <= 1'b1;
        wait_valid();
        apb(1'b0, 12'h00C, 32'h0, rd, err);
        check("unmapped err", 32'(err), 32'h1);
        check("unmapped data", rd, 32'h0);
        apb(1'b0, REG_CTRL, 32'h0, rd, err);
        check("ctrl read", rd, 32'h0);
        apb(1'b1, REG_CONFIG, $random(seed), rd, err);
        check("config write err", 32'(err), 32'h0);
        apb(1'b1, REG_STATUS, $random(seed), rd, err);
        check("status write err", 32'(err), 32'h0);
        for (int m = 0; m < 3; m++)
            for (int s = 0; s < 3; s++)
                for (int e = 0; e < 3; e++)
                begin
                    @(posedge sys_clk_i);
                    pin_st[PIN_MODE] <= ssd_pin_e'(m);
                    pin_st[PIN_SWING] <= ssd_pin_e'(s);
                    pin_st[PIN_EDGE] <= ssd_pin_e'(e);
                    apb(1'b1, REG_CTRL, 32'h1, rd, err);
                    repeat (2) @(posedge sys_clk_i);
                    #1;
                    check("valid drop", 32'(cfg.valid), 32'h0);
                    check("probe oe", 32'(strap_oe), 32'h7);
                    apb(1'b0, REG_STATUS, 32'h0, rd, err);
                    check("probing", 32'({rd[ST_PROBING_BIT], rd[ST_VALID_BIT]}), 32'h2);
                    wait_valid();
                    // edge bit stays low under double rate
                    exp = model(m, s, e);
                    check("cfg", 32'(cfg), 32'(exp));
                    apb(1'b0, REG_STATUS, 32'h0, rd, err);
                    check("status", rd, {20'h0, 1'b0, exp.swing_fault, exp.ext_ctrl, 1'b1,
                        2'h0, 2'(m), 2'(e), 2'(s)});
                    apb(1'b0, REG_CONFIG, 32'h0, rd, err);
                    check("config", rd, {28'h0, exp.ddr, exp.edge_pos, exp.swing_700,
                        exp.range_870});
                    repeat (3)
                    begin
                        rnd = 3'($random(seed));
                        @(posedge sys_clk_i);
                        pin_st[PIN_SWING] <= rnd[0] ? SSD_PIN_HIGH : SSD_PIN_LOW;
                        pin_st[PIN_EDGE] <= rnd[1] ? SSD_PIN_HIGH : SSD_PIN_LOW;
                        sel_n <= rnd[2];
                        repeat (2) @(posedge sys_clk_i);
                        #1;
                        check("ser clk", 32'(ser_clk), 32'(exp.ext_ctrl & rnd[0]));
                        check("ser data", 32'(ser_dat), 32'(exp.ext_ctrl & rnd[1]));
                        check("ser sel", 32'(ser_sel), 32'(exp.ext_ctrl & ~rnd[2]));
                        check("cfg static", 32'(cfg), 32'(exp));
                    end
                end
        final_report();
    end
endmodule : test_ssd_strap_decoder
